// ### bls_backlight_sequencer.sv
// backlight on/dim/off sequencer with countdown timers, fades and zones
//
// Notes on behaviour
// - enable and on bits set drive the daylight maximum current
// - a new maximum setting written while lit changes the drive
// - clearing the on bit turns the backlight off
// - setting the dim bit while lit drops drive to the dim setting
// - clearing the dim bit returns drive to the maximum setting
// - a nonzero dim time starts counting down at turn-on
// - dim expiry sets the dim bit and drops to dim current
// - off time alone counts from turn-on, expiry clears on bit
// - with both times, off countdown starts once dim level is reached
// - off expiry after auto dim clears both dim and on bits
// - software clearing on abandons any countdown and turns off
// - programmed fade-in ramps current from zero up to target
// - programmed fade-out ramps current down to zero
// - selectable linear or square law shapes every ramp
// - ramps also apply to timer-driven dim and off changes
// - zone field picks daylight, office or dark current settings
// - reset leaves the daylight zone selected
// - zone changes move current smoothly when fades are enabled
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "bls_defs.svh"

module bls_backlight_sequencer #(
    parameter int unsigned TIMER_TICK_CYCLES = `BLS_TIMER_TICK_CYCLES,
    parameter int unsigned FADE_STEP_CYCLES = `BLS_FADE_STEP_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // backlight drive
    output logic [7:0] o_bl_current,
    output logic o_bl_lit,
    output bls_pkg::bls_seq_type o_seq_state
);
    import bls_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] main_reg;
    logic [7:0] main_next;
    logic [7:0] bl_ctrl_reg;
    logic [7:0] timers_reg;
    logic [7:0] fade_reg;
    logic [7:0] cur_set_reg [0:5];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wr_main;
    logic dim_expire;
    logic off_expire;

    assign wr_main = i_wr && (i_addr == `BLS_ADDR_MAIN);

    always_comb begin
        main_next = main_reg;
        if (wr_main) begin
            main_next = i_wdata & `BLS_MAIN_MASK;
        end
        // a fresh turn-on written in the expiry cycle is kept
        if (off_expire && !wr_main) begin
            main_next[`BLS_MAIN_ON_BIT] = 1'b0;
            main_next[`BLS_MAIN_DIM_BIT] = 1'b0;
        end
        // hardware set beats a software clear in the same cycle
        if (dim_expire) begin
            main_next[`BLS_MAIN_DIM_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            main_reg <= `BLS_REG_RESET;
        end else begin
            main_reg <= main_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            bl_ctrl_reg <= `BLS_REG_RESET;
            timers_reg <= `BLS_REG_RESET;
            fade_reg <= `BLS_REG_RESET;
            for (int i = 0; i < 6; i++) begin
                cur_set_reg[i] <= `BLS_REG_RESET;
            end
        end else if (i_wr) begin
            if (i_addr == `BLS_ADDR_BL_CTRL) begin
                bl_ctrl_reg <= i_wdata;
            end
            if (i_addr == `BLS_ADDR_TIMERS) begin
                timers_reg <= i_wdata;
            end
            if (i_addr == `BLS_ADDR_FADE) begin
                fade_reg <= i_wdata;
            end
            if ((i_addr >= `BLS_ADDR_DAY_MAX) && (i_addr <= `BLS_ADDR_DARK_DIM)) begin
                cur_set_reg[3'(i_addr - `BLS_ADDR_DAY_MAX)] <= i_wdata & `BLS_CUR_MASK;
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        rdata_next = 8'h00;
        if ((i_addr >= `BLS_ADDR_DAY_MAX) && (i_addr <= `BLS_ADDR_DARK_DIM)) begin
            rdata_next = cur_set_reg[3'(i_addr - `BLS_ADDR_DAY_MAX)];
        end else if (i_addr == `BLS_ADDR_MAIN) begin
            rdata_next = main_reg;
        end else if (i_addr == `BLS_ADDR_BL_CTRL) begin
            rdata_next = bl_ctrl_reg;
        end else if (i_addr == `BLS_ADDR_TIMERS) begin
            rdata_next = timers_reg;
        end else if (i_addr == `BLS_ADDR_FADE) begin
            rdata_next = fade_reg;
        end else if (i_addr == `BLS_ADDR_PRESENT) begin
            rdata_next = o_bl_current;
        end
    end

    // data valid only in the cycle after the strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= i_rd ? rdata_next : 8'h00;
        end
    end

    assign o_rdata = rdata_reg;

    // ****************************************
    // on / dim sequencing
    // ****************************************
    bls_seq_type seq_reg;
    logic lit;
    logic dim_on;
    logic [3:0] dim_code;
    logic [3:0] off_code;
    logic [3:0] fin_code;
    logic [3:0] fout_code;
    bls_zone_type zone;
    bls_law_type law;

    assign lit = main_reg[`BLS_MAIN_EN_BIT] && main_reg[`BLS_MAIN_ON_BIT];
    assign dim_on = main_reg[`BLS_MAIN_DIM_BIT];
    assign dim_code = timers_reg[`BLS_DIM_T_MSB:`BLS_DIM_T_LSB];
    assign off_code = timers_reg[`BLS_OFF_T_MSB:`BLS_OFF_T_LSB];
    assign fin_code = fade_reg[`BLS_FIN_MSB:`BLS_FIN_LSB];
    assign fout_code = fade_reg[`BLS_FOUT_MSB:`BLS_FOUT_LSB];
    assign zone = bls_zone_type'(bl_ctrl_reg[`BLS_ZONE_MSB:`BLS_ZONE_LSB]);
    assign law = bls_law_type'(bl_ctrl_reg[`BLS_LAW_BIT]);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            seq_reg <= BLS_SEQ_IDLE;
        end else if (!lit) begin
            seq_reg <= BLS_SEQ_IDLE;
        end else begin
            unique case (seq_reg)
                BLS_SEQ_IDLE: begin
                    seq_reg <= dim_on ? BLS_SEQ_DIMMED : BLS_SEQ_BRIGHT;
                end
                BLS_SEQ_BRIGHT: begin
                    if (dim_on) begin
                        seq_reg <= BLS_SEQ_DIMMED;
                    end
                end
                BLS_SEQ_DIMMED: begin
                    if (!dim_on) begin
                        seq_reg <= BLS_SEQ_BRIGHT;
                    end
                end
                default: begin
                    seq_reg <= BLS_SEQ_IDLE;
                end
            endcase
        end
    end

    assign o_seq_state = seq_reg;
    assign o_bl_lit = lit;

    // ****************************************
    // countdown timers
    // ****************************************
    logic settled;
    logic dim_run;
    logic off_run;
    logic [3:0] limit;
    logic [31:0] pre_cnt_reg;
    logic [3:0] tick_cnt_reg;
    logic tick;
    logic expire;

    // counting restarts from zero whenever the run condition drops
    assign dim_run = (seq_reg == BLS_SEQ_BRIGHT) && (dim_code != 4'h0) && !dim_on;
    assign off_run = (off_code != 4'h0) &&
        (((seq_reg == BLS_SEQ_BRIGHT) && (dim_code == 4'h0)) ||
         ((seq_reg == BLS_SEQ_DIMMED) && settled));
    assign limit = dim_run ? dim_code : off_code;
    assign tick = (pre_cnt_reg == (TIMER_TICK_CYCLES - 1));
    assign expire = tick && (tick_cnt_reg == (limit - 4'h1));
    assign dim_expire = expire && dim_run;
    assign off_expire = expire && off_run;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pre_cnt_reg <= 32'h0;
            tick_cnt_reg <= 4'h0;
        end else if (!(dim_run || off_run) || expire) begin
            pre_cnt_reg <= 32'h0;
            tick_cnt_reg <= 4'h0;
        end else if (tick) begin
            pre_cnt_reg <= 32'h0;
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 32'h1;
        end
    end

    // ****************************************
    // target level and fade ramp
    // ****************************************
    logic [7:0] target;
    logic [7:0] max_cur;
    logic [7:0] dim_cur;
    logic [7:0] tgt_reg;
    logic [7:0] start_reg;
    logic [7:0] cur_reg;
    logic [7:0] phase_reg;
    logic [31:0] step_reg;
    logic [3:0] kick_code;
    logic [3:0] ramp_code;
    logic [31:0] step_len;
    logic [7:0] phase_inc;
    logic [15:0] sq;
    logic [7:0] weight;
    logic signed [8:0] diff;
    logic signed [17:0] prod;
    logic signed [8:0] blend_sum;

    always_comb begin
        unique case (zone)
            BLS_ZONE_OFFICE: begin
                max_cur = cur_set_reg[2];
                dim_cur = cur_set_reg[3];
            end
            BLS_ZONE_DARK: begin
                max_cur = cur_set_reg[4];
                dim_cur = cur_set_reg[5];
            end
            BLS_ZONE_DAY, BLS_ZONE_RSVD: begin
                max_cur = cur_set_reg[0];
                dim_cur = cur_set_reg[1];
            end
        endcase
    end

    assign target = !lit ? 8'h00 : (dim_on ? dim_cur : max_cur);

    // rising moves use fade-in time, falling ones fade-out time
    assign kick_code = (target > cur_reg) ? fin_code : fout_code;
    assign ramp_code = (tgt_reg >= start_reg) ? fin_code : fout_code;
    assign step_len = 32'(ramp_code) * FADE_STEP_CYCLES;
    assign settled = (phase_reg == `BLS_PHASE_DONE);

    // weight runs 1..255 across the ramp (0..254 for square law); square law eases in
    assign phase_inc = phase_reg + 8'h01;
    assign sq = phase_inc * phase_inc;
    assign weight = (law == BLS_LAW_SQUARE) ? sq[15:8] : phase_inc;
    assign diff = $signed({1'b0, tgt_reg}) - $signed({1'b0, start_reg});
    assign prod = diff * $signed({1'b0, weight});
    assign blend_sum = $signed({1'b0, start_reg}) + $signed(prod[16:8]);

    // any target change (timers, bus, zone) restarts the ramp from the present level
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            tgt_reg <= 8'h00;
            start_reg <= 8'h00;
            cur_reg <= 8'h00;
            phase_reg <= `BLS_PHASE_DONE;
            step_reg <= 32'h0;
        end else if (target != tgt_reg) begin
            tgt_reg <= target;
            start_reg <= cur_reg;
            step_reg <= 32'h0;
            if (kick_code == 4'h0) begin
                cur_reg <= target;
                phase_reg <= `BLS_PHASE_DONE;
            end else begin
                phase_reg <= 8'h00;
            end
        end else if (!settled) begin
            if (ramp_code == 4'h0) begin
                cur_reg <= tgt_reg;
                phase_reg <= `BLS_PHASE_DONE;
            end else if (step_reg >= (step_len - 32'h1)) begin
                step_reg <= 32'h0;
                phase_reg <= phase_inc;
                // last step lands exactly, hiding truncation error
                cur_reg <= (phase_inc == `BLS_PHASE_DONE) ? tgt_reg : blend_sum[7:0];
            end else begin
                step_reg <= step_reg + 32'h1;
            end
        end
    end

    assign o_bl_current = cur_reg;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_fade_kick;
        (target != tgt_reg) && (kick_code != 4'h0);
    endsequence

    sequence s_fade_hold;
        (phase_reg == 8'h00) && (cur_reg == $past(cur_reg));
    endsequence

    property p_day_max;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (lit && !dim_on && (zone == BLS_ZONE_DAY) && (fade_reg == 8'h00))
        |=> (cur_reg == $past(cur_set_reg[0]));
    endproperty
    a_day_max: assert property (p_day_max) else $error("daylight max not driven");

    property p_day_dim;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (lit && dim_on && (zone == BLS_ZONE_DAY) && (fade_reg == 8'h00))
        |=> (cur_reg == $past(cur_set_reg[1]));
    endproperty
    a_day_dim: assert property (p_day_dim) else $error("dim level not driven");

    property p_office_max;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (lit && !dim_on && (zone == BLS_ZONE_OFFICE) && (fade_reg == 8'h00))
        |=> (cur_reg == $past(cur_set_reg[2]));
    endproperty
    a_office_max: assert property (p_office_max) else $error("office max not driven");

    property p_off_cut;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!lit && (fade_reg == 8'h00)) |=> (cur_reg == 8'h00);
    endproperty
    a_off_cut: assert property (p_off_cut) else $error("backlight not off");

    property p_dim_expire;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        dim_expire |=> main_reg[`BLS_MAIN_DIM_BIT] ##1 (seq_reg != BLS_SEQ_BRIGHT);
    endproperty
    a_dim_expire: assert property (p_dim_expire) else $error("auto dim missing");

    property p_off_expire;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (off_expire && !wr_main)
        |=> (!main_reg[`BLS_MAIN_ON_BIT] && !main_reg[`BLS_MAIN_DIM_BIT]);
    endproperty
    a_off_expire: assert property (p_off_expire) else $error("auto off missing");

    property p_abandon;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !lit |=> (seq_reg == BLS_SEQ_IDLE) && !dim_expire && !off_expire;
    endproperty
    a_abandon: assert property (p_abandon) else $error("countdown not abandoned");

    property p_off_waits;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (off_expire && (dim_code != 4'h0)) |-> (seq_reg == BLS_SEQ_DIMMED) && (cur_reg == tgt_reg);
    endproperty
    a_off_waits: assert property (p_off_waits) else $error("off timer ran early");

    property p_fade_start;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        s_fade_kick |=> s_fade_hold;
    endproperty
    a_fade_start: assert property (p_fade_start) else $error("ramp stepped at start");

    property p_ramp_end;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        settled |-> (cur_reg == tgt_reg);
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("ramp ended off target");
endmodule

// ### bls_defs.svh
// register map, field positions, reset values and timing constants
`ifndef BLS_DEFS_SVH
`define BLS_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define BLS_ADDR_MAIN 8'h00
`define BLS_ADDR_BL_CTRL 8'h02
`define BLS_ADDR_TIMERS 8'h03
`define BLS_ADDR_FADE 8'h04
`define BLS_ADDR_DAY_MAX 8'h05
`define BLS_ADDR_DAY_DIM 8'h06
`define BLS_ADDR_OFFICE_MAX 8'h07
`define BLS_ADDR_OFFICE_DIM 8'h08
`define BLS_ADDR_DARK_MAX 8'h09
`define BLS_ADDR_DARK_DIM 8'h0a
`define BLS_ADDR_PRESENT 8'h0b

// ****************************************
// field positions
// ****************************************
`define BLS_MAIN_EN_BIT 7
`define BLS_MAIN_ON_BIT 6
`define BLS_MAIN_DIM_BIT 5
`define BLS_MAIN_MASK 8'he0
`define BLS_ZONE_MSB 7
`define BLS_ZONE_LSB 6
`define BLS_LAW_BIT 5
`define BLS_DIM_T_MSB 3
`define BLS_DIM_T_LSB 0
`define BLS_OFF_T_MSB 7
`define BLS_OFF_T_LSB 4
`define BLS_FIN_MSB 3
`define BLS_FIN_LSB 0
`define BLS_FOUT_MSB 7
`define BLS_FOUT_LSB 4
`define BLS_CUR_MASK 8'h7f

// ****************************************
// reset values
// ****************************************
`define BLS_REG_RESET 8'h00
`define BLS_PHASE_DONE 8'hff

// ****************************************
// timing
// ****************************************
`define BLS_CLK_KHZ 20000
`define BLS_TIMER_TICK_MS 1000
`define BLS_TIMER_TICK_CYCLES (`BLS_TIMER_TICK_MS * `BLS_CLK_KHZ)
`define BLS_FADE_UNIT_MS 100
`define BLS_FADE_STEPS 256
`define BLS_FADE_STEP_CYCLES ((`BLS_FADE_UNIT_MS * `BLS_CLK_KHZ) / `BLS_FADE_STEPS)

`endif

// ### bls_pkg.sv
// types shared by the backlight sequencer
package bls_pkg;
    typedef enum logic [1:0] {
        BLS_ZONE_DAY = 2'b00,
        BLS_ZONE_OFFICE = 2'b01,
        BLS_ZONE_DARK = 2'b10,
        BLS_ZONE_RSVD = 2'b11
    } bls_zone_type;

    typedef enum logic [1:0] {
        BLS_SEQ_IDLE = 2'b00,
        BLS_SEQ_BRIGHT = 2'b01,
        BLS_SEQ_DIMMED = 2'b10
    } bls_seq_type;

    typedef enum logic {
        BLS_LAW_LINEAR = 1'b0,
        BLS_LAW_SQUARE = 1'b1
    } bls_law_type;
endpackage

// ### bls_testbench.sv
// self-checking testbench for the backlight sequencer
`timescale 1ns/1ps
`include "bls_defs.svh"

`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin fail_count++; \
    $display("Error at %0t: mismatch got %h expected %h", $time, (act), (exp)); end end

module testbench;
    import bls_pkg::*;

    // ****************************************
    // signals and design
    // ****************************************
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic [7:0] o_bl_current;
    logic o_bl_lit;
    bls_seq_type o_seq_state;
    int fail_count = 0;
    int n_checks = 0;

    // short counts keep every timer and ramp inside a few hundred cycles
    bls_backlight_sequencer #(.TIMER_TICK_CYCLES(4), .FADE_STEP_CYCLES(1)) dut (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_bl_current(o_bl_current),
        .o_bl_lit(o_bl_lit),
        .o_seq_state(o_seq_state)
    );

    always #25 i_clk_sys = ~i_clk_sys;

    // ****************************************
    // bus and helper tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
        `CHK(d, e)
    endtask

    // a short reset before each scenario also exercises reset in mid-run
    task automatic do_reset();
        @(posedge i_clk_sys);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        cyc(1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_map();
        do_reset();
        `CHK({o_bl_lit, o_bl_current, o_seq_state}, {1'b0, 8'h00, BLS_SEQ_IDLE})
        chk_rd(`BLS_ADDR_MAIN, 8'h00);
        wr(8'h01, 8'h55);
        chk_rd(8'h01, 8'h00);
        wr(`BLS_ADDR_MAIN, 8'h9f);
        chk_rd(`BLS_ADDR_MAIN, 8'h80);
        wr(`BLS_ADDR_DAY_MAX, 8'hff);
        chk_rd(`BLS_ADDR_DAY_MAX, 8'h7f);
        wr(`BLS_ADDR_PRESENT, 8'h33);
        chk_rd(`BLS_ADDR_PRESENT, 8'h00);
    endtask

    task automatic t_turn_on();
        do_reset();
        wr(`BLS_ADDR_DAY_MAX, 8'h1e);
        wr(`BLS_ADDR_MAIN, 8'hc0);
        cyc(2);
        `CHK({o_bl_lit, o_bl_current, o_seq_state}, {1'b1, 8'h1e, BLS_SEQ_BRIGHT})
        wr(`BLS_ADDR_DAY_MAX, 8'h2a);
        cyc(2);
        `CHK(o_bl_current, 8'h2a)
        chk_rd(`BLS_ADDR_PRESENT, 8'h2a);
        wr(`BLS_ADDR_MAIN, 8'h80);
        cyc(2);
        `CHK({o_bl_lit, o_bl_current}, {1'b0, 8'h00})
        wr(`BLS_ADDR_MAIN, 8'h40);
        cyc(2);
        `CHK({o_bl_lit, o_bl_current}, {1'b0, 8'h00})
    endtask

    task automatic t_manual_dim();
        do_reset();
        wr(`BLS_ADDR_DAY_MAX, 8'h1e);
        wr(`BLS_ADDR_DAY_DIM, 8'h05);
        wr(`BLS_ADDR_MAIN, 8'hc0);
        wr(`BLS_ADDR_MAIN, 8'he0);
        cyc(2);
        `CHK({o_bl_current, o_seq_state}, {8'h05, BLS_SEQ_DIMMED})
        wr(`BLS_ADDR_MAIN, 8'hc0);
        cyc(2);
        `CHK(o_bl_current, 8'h1e)
    endtask

    task automatic t_zones();
        do_reset();
        wr(`BLS_ADDR_DAY_MAX, 8'h1e);
        wr(`BLS_ADDR_OFFICE_MAX, 8'h0c);
        wr(`BLS_ADDR_DARK_MAX, 8'h03);
        wr(`BLS_ADDR_MAIN, 8'hc0);
        wr(`BLS_ADDR_BL_CTRL, 8'h40);
        cyc(2);
        `CHK(o_bl_current, 8'h0c)
        wr(`BLS_ADDR_BL_CTRL, 8'h80);
        cyc(2);
        `CHK(o_bl_current, 8'h03)
        wr(`BLS_ADDR_BL_CTRL, 8'h00);
        cyc(2);
        `CHK(o_bl_current, 8'h1e)
    endtask

    // timers: low nibble dim ticks, high nibble off ticks, one tick is four cycles
    task automatic t_auto(input logic [7:0] tmr);
        do_reset();
        wr(`BLS_ADDR_DAY_MAX, 8'h1e);
        wr(`BLS_ADDR_DAY_DIM, 8'h05);
        wr(`BLS_ADDR_TIMERS, tmr);
        wr(`BLS_ADDR_MAIN, 8'hc0);
        cyc(3);
        `CHK({o_bl_current, o_seq_state}, {8'h1e, BLS_SEQ_BRIGHT})
    endtask

    task automatic t_timers();
        t_auto(8'h02);
        cyc(15);
        `CHK({o_bl_current, o_seq_state}, {8'h05, BLS_SEQ_DIMMED})
        chk_rd(`BLS_ADDR_MAIN, 8'he0);
        t_auto(8'h20);
        cyc(15);
        `CHK({o_bl_lit, o_bl_current}, {1'b0, 8'h00})
        chk_rd(`BLS_ADDR_MAIN, 8'h80);
        t_auto(8'h22);
        cyc(13);
        `CHK({o_bl_lit, o_bl_current}, {1'b1, 8'h05})
        cyc(20);
        `CHK({o_bl_lit, o_bl_current}, {1'b0, 8'h00})
        chk_rd(`BLS_ADDR_MAIN, 8'h80);
        t_auto(8'h22);
        wr(`BLS_ADDR_MAIN, 8'h80);
        cyc(40);
        `CHK({o_bl_lit, o_bl_current}, {1'b0, 8'h00})
        chk_rd(`BLS_ADDR_MAIN, 8'h80);
    endtask

    // fade set once the light is up: the auto dim ramps down, off waits for the dim level
    task automatic t_fade_timers();
        do_reset();
        wr(`BLS_ADDR_DAY_MAX, 8'h7f);
        wr(`BLS_ADDR_DAY_DIM, 8'h03);
        wr(`BLS_ADDR_TIMERS, 8'h22);
        wr(`BLS_ADDR_MAIN, 8'hc0);
        wr(`BLS_ADDR_FADE, 8'h11);
        cyc(28);
        `CHK({o_bl_lit, o_seq_state}, {1'b1, BLS_SEQ_DIMMED})
        `CHK(o_bl_current > 8'h03 && o_bl_current < 8'h7f, 1'b1)
        cyc(238);
        `CHK({o_bl_lit, o_bl_current}, {1'b1, 8'h03})
        cyc(12);
        `CHK({o_bl_lit, o_seq_state}, {1'b0, BLS_SEQ_IDLE})
        `CHK(o_bl_current > 8'h00 && o_bl_current < 8'h04, 1'b1)
        cyc(260);
        `CHK(o_bl_current, 8'h00)
        chk_rd(`BLS_ADDR_MAIN, 8'h80);
    endtask

    // 255 steps of one cycle each; the mid-ramp bounds tell linear from square
    task automatic t_fade();
        do_reset();
        wr(`BLS_ADDR_DAY_MAX, 8'h7f);
        wr(`BLS_ADDR_DARK_MAX, 8'h03);
        wr(`BLS_ADDR_FADE, 8'h11);
        wr(`BLS_ADDR_MAIN, 8'hc0);
        cyc(20);
        `CHK(o_bl_current > 8'h00 && o_bl_current < 8'h7f, 1'b1)
        cyc(108);
        `CHK(o_bl_current > 8'h32 && o_bl_current < 8'h50, 1'b1)
        cyc(200);
        `CHK(o_bl_current, 8'h7f)
        wr(`BLS_ADDR_BL_CTRL, 8'h80);
        cyc(20);
        `CHK(o_bl_current > 8'h03 && o_bl_current < 8'h7f, 1'b1)
        cyc(300);
        `CHK(o_bl_current, 8'h03)
        wr(`BLS_ADDR_BL_CTRL, 8'h20);
        cyc(300);
        `CHK(o_bl_current, 8'h7f)
        wr(`BLS_ADDR_MAIN, 8'h80);
        cyc(128);
        `CHK(o_bl_current > 8'h50 && o_bl_current < 8'h7f, 1'b1)
        cyc(200);
        `CHK(o_bl_current, 8'h00)
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        cyc(1);
        t_reset_map();
        t_turn_on();
        t_manual_dim();
        t_zones();
        t_timers();
        t_fade_timers();
        t_fade();
        tally_and_finish();
    end

    // whole run is about two thousand cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fail_count++;
        tally_and_finish();
    end
endmodule
